// File: cfc_regs.svh
// Constants for the flow control instruction unit
`ifndef CFC_REGS_SVH
`define CFC_REGS_SVH
`define CFC_PC_W 12
`define CFC_SP_W 8
`define CFC_SP_STEP 8'h02
`define CFC_PC_ONE 12'h001
`define CFC_PC_RST 12'h000
`define CFC_SP_RST 8'h00
`define CFC_ACC_RST 8'h00
`endif

// File: cfc_pkg.sv
// Types for the flow control instruction unit
package cfc_pkg;
  typedef enum logic [3:0] {
    CFC_OP_NOP = 4'h0,
    CFC_OP_CALL = 4'h1,
    CFC_OP_GOTO = 4'h2,
    CFC_OP_RETV = 4'h3,
    CFC_OP_RET = 4'h4,
    CFC_OP_RETI = 4'h5,
    CFC_OP_PCADD = 4'h6,
    CFC_OP_GIE_ON = 4'h7,
    CFC_OP_GIE_OFF = 4'h8,
    CFC_OP_HALT_SYS = 4'h9,
    CFC_OP_HALT_CPU = 4'ha,
    CFC_OP_SWRST = 4'hb,
    CFC_OP_WDCLR = 4'hc
  } cfc_op_t;
  typedef enum logic [1:0] {
    CFC_ST_RUN = 2'b00,
    CFC_ST_EXEC2 = 2'b01,
    CFC_ST_HALT = 2'b10
  } cfc_state_t;
endpackage

// File: cfc_core.sv
// Flow control instruction unit of an 8-bit core
`timescale 1ns/1ps
`include "cfc_regs.svh"
// Operation
// RL1: Call pushes pc+1, jumps, sp grows 2
// RL2: Jump loads full-range target address
// RL3: Return-with-value loads immediate, then returns
// RL4: Return drops sp by 2, reloads pc
// RL5: Interrupt return also sets global enable
// RL6: Computed jump adds working register to pc
// RL7: Enable instruction sets global interrupt enable
// RL8: Disable instruction clears global interrupt enable
// RL9: Full halt stops all clocks, oscillators too
// RL10: CPU halt gates core clock, oscillators run
// RL11: Software reset resets whole chip
// RL12: Watchdog restart clears watchdog count
// RL13: No-op only advances program counter
// RL14: No flag changes by these instructions
// RL15: Branches take two cycles, others one; here software reset also takes two, halts last until wake
// RL16: Halt holds pc, resumes on wake
// RL17: Pc arithmetic wraps at address width
module cfc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction issue
  input wire logic instr_valid,
  input wire cfc_pkg::cfc_op_t instr_op,
  input wire logic [`CFC_PC_W-1:0] instr_target,
  input wire logic [7:0] instr_imm,
  output logic instr_ready,
  // Stack memory port
  output logic stack_wr,
  output logic [`CFC_SP_W-1:0] stack_addr,
  output logic [`CFC_PC_W-1:0] stack_wdata,
  input wire logic [`CFC_PC_W-1:0] stack_rdata,
  // Wake request from outside the core domain
  input wire logic wake_req,
  // Core state
  output logic [`CFC_PC_W-1:0] program_counter,
  output logic [`CFC_SP_W-1:0] stack_pointer,
  output logic [7:0] working_register,
  output logic global_int_en,
  output logic flags_we,
  // System controls
  output logic osc_stop,
  output logic core_clk_gate,
  output logic chip_reset_req,
  output logic wdt_clear
);
  // ==========================================================
  // Wake synchroniser
  logic wake_s1_ff, wake_s2_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
    end else begin
      wake_s1_ff <= wake_req;
      wake_s2_ff <= wake_s1_ff;
    end
  end
  // ==========================================================
  // Execution state
  cfc_pkg::cfc_state_t state_ff, nxt_state;
  cfc_pkg::cfc_op_t op_ff, nxt_op;
  logic [`CFC_PC_W-1:0] pc_ff, nxt_pc, tgt_ff, nxt_tgt;
  logic [`CFC_SP_W-1:0] sp_ff, nxt_sp;
  logic [7:0] acc_ff, nxt_acc;
  logic gie_ff, nxt_gie, osc_ff, nxt_osc, gate_ff, nxt_gate;
  logic rst_ff, nxt_rst, wdt_ff, nxt_wdt;
  logic wr_ff, nxt_wr;
  logic [`CFC_PC_W-1:0] wdata_ff, nxt_wdata;
  logic [`CFC_SP_W-1:0] addr_ff, nxt_addr;
  logic take;
  assign take = instr_valid && instr_ready;
  assign instr_ready = (state_ff == cfc_pkg::CFC_ST_RUN) && !rst_ff;
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_pc = pc_ff;
    nxt_tgt = tgt_ff;
    nxt_sp = sp_ff;
    nxt_acc = acc_ff;
    nxt_gie = gie_ff;
    nxt_osc = osc_ff;
    nxt_gate = gate_ff;
    nxt_rst = 1'b0;
    nxt_wdt = 1'b0;
    nxt_wr = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_addr = addr_ff;
    case (state_ff)
      cfc_pkg::CFC_ST_RUN: begin
        if (take) begin
          nxt_op = instr_op;
          nxt_pc = pc_ff + `CFC_PC_ONE; // [RL13] [RL17]
          case (instr_op)
            cfc_pkg::CFC_OP_CALL: begin
              nxt_wr = 1'b1; // [RL1]
              nxt_addr = sp_ff;
              nxt_wdata = pc_ff + `CFC_PC_ONE; // [RL17]
              nxt_tgt = instr_target;
              nxt_state = cfc_pkg::CFC_ST_EXEC2; // [RL15]
            end
            cfc_pkg::CFC_OP_GOTO: begin
              nxt_tgt = instr_target; // [RL2]
              nxt_state = cfc_pkg::CFC_ST_EXEC2;
            end
            cfc_pkg::CFC_OP_RET, cfc_pkg::CFC_OP_RETI, cfc_pkg::CFC_OP_RETV: begin
              if (instr_op == cfc_pkg::CFC_OP_RETV) begin
                nxt_acc = instr_imm; // [RL3]
              end
              nxt_sp = sp_ff - `CFC_SP_STEP; // [RL4]
              nxt_addr = sp_ff - `CFC_SP_STEP;
              nxt_state = cfc_pkg::CFC_ST_EXEC2;
            end
            cfc_pkg::CFC_OP_PCADD: begin
              nxt_tgt = pc_ff + {{(`CFC_PC_W-8){1'b0}}, acc_ff}; // [RL6] [RL17]
              nxt_state = cfc_pkg::CFC_ST_EXEC2;
            end
            cfc_pkg::CFC_OP_GIE_ON: nxt_gie = 1'b1; // [RL7]
            cfc_pkg::CFC_OP_GIE_OFF: nxt_gie = 1'b0; // [RL8]
            cfc_pkg::CFC_OP_HALT_SYS: begin
              nxt_osc = 1'b1; // [RL9]
              nxt_gate = 1'b1;
              nxt_state = cfc_pkg::CFC_ST_HALT; // [RL16]
            end
            cfc_pkg::CFC_OP_HALT_CPU: begin
              nxt_gate = 1'b1; // [RL10]
              nxt_state = cfc_pkg::CFC_ST_HALT;
            end
            cfc_pkg::CFC_OP_SWRST: nxt_rst = 1'b1; // [RL11]
            cfc_pkg::CFC_OP_WDCLR: nxt_wdt = 1'b1; // [RL12]
            default: ;
          endcase
        end
      end
      cfc_pkg::CFC_ST_EXEC2: begin
        nxt_state = cfc_pkg::CFC_ST_RUN;
        case (op_ff)
          cfc_pkg::CFC_OP_CALL: begin
            nxt_pc = tgt_ff; // [RL1]
            nxt_sp = sp_ff + `CFC_SP_STEP;
          end
          cfc_pkg::CFC_OP_RET, cfc_pkg::CFC_OP_RETV: nxt_pc = stack_rdata; // [RL4]
          cfc_pkg::CFC_OP_RETI: begin
            nxt_pc = stack_rdata;
            nxt_gie = 1'b1; // [RL5]
          end
          default: nxt_pc = tgt_ff; // [RL2] [RL6]
        endcase
      end
      cfc_pkg::CFC_ST_HALT: begin
        // Pc already points past the halt, so wake resumes there
        if (wake_s2_ff) begin
          nxt_osc = 1'b0; // [RL16]
          nxt_gate = 1'b0;
          nxt_state = cfc_pkg::CFC_ST_RUN;
        end
      end
      default: nxt_state = cfc_pkg::CFC_ST_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= cfc_pkg::CFC_ST_RUN;
      op_ff <= cfc_pkg::CFC_OP_NOP;
      pc_ff <= `CFC_PC_RST;
      tgt_ff <= `CFC_PC_RST;
      sp_ff <= `CFC_SP_RST;
      acc_ff <= `CFC_ACC_RST;
      gie_ff <= 1'b0;
      osc_ff <= 1'b0;
      gate_ff <= 1'b0;
      rst_ff <= 1'b0;
      wdt_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= `CFC_PC_RST;
      addr_ff <= `CFC_SP_RST;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      pc_ff <= nxt_pc;
      tgt_ff <= nxt_tgt;
      sp_ff <= nxt_sp;
      acc_ff <= nxt_acc;
      gie_ff <= nxt_gie;
      osc_ff <= nxt_osc;
      gate_ff <= nxt_gate;
      rst_ff <= nxt_rst;
      wdt_ff <= nxt_wdt;
      wr_ff <= nxt_wr;
      wdata_ff <= nxt_wdata;
      addr_ff <= nxt_addr;
    end
  end
  // ==========================================================
  // Outputs
  assign program_counter = pc_ff;
  assign stack_pointer = sp_ff;
  assign working_register = acc_ff;
  assign global_int_en = gie_ff;
  assign flags_we = 1'b0; // [RL14]
  assign osc_stop = osc_ff;
  assign core_clk_gate = gate_ff;
  assign chip_reset_req = rst_ff;
  assign wdt_clear = wdt_ff;
  assign stack_wr = wr_ff;
  assign stack_addr = addr_ff;
  assign stack_wdata = wdata_ff;
  // ==========================================================
  // Checks
  // Call is checked as three steps: accept, push, then stack pointer step
  sequence s_call;
    take && instr_op == cfc_pkg::CFC_OP_CALL;
  endsequence
  sequence s_push;
    stack_wr && stack_addr == $past(sp_ff);
  endsequence
  sequence s_sp_up;
    sp_ff == $past(sp_ff, 2) + `CFC_SP_STEP;
  endsequence
  property p_call;
    @(posedge clk) disable iff (!rst_b)
    s_call |=> s_push ##1 s_sp_up;
  endproperty
  a_call: assert property (p_call) else $error("call push wrong"); // [RL1]
  property p_goto;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_GOTO) |=> ##1 (pc_ff == $past(instr_target, 2));
  endproperty
  a_goto: assert property (p_goto) else $error("goto target wrong"); // [RL2]
  property p_retv;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_RETV) |=> (acc_ff == $past(instr_imm));
  endproperty
  a_retv: assert property (p_retv) else $error("return value wrong"); // [RL3]
  property p_ret;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_RET) |=> (sp_ff == $past(sp_ff) - `CFC_SP_STEP);
  endproperty
  a_ret: assert property (p_ret) else $error("return sp wrong"); // [RL4]
  property p_reti;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_RETI) |=> ##1 gie_ff;
  endproperty
  a_reti: assert property (p_reti) else $error("reti no enable"); // [RL5]
  property p_gie;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_GIE_OFF) |=> !gie_ff;
  endproperty
  a_gie: assert property (p_gie) else $error("disable failed"); // [RL8]
  sequence s_halt;
    take && instr_op == cfc_pkg::CFC_OP_HALT_CPU;
  endsequence
  property p_halt;
    @(posedge clk) disable iff (!rst_b)
    s_halt |=> core_clk_gate && !osc_stop && !instr_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("cpu halt wrong"); // [RL10]
  property p_nop;
    @(posedge clk) disable iff (!rst_b)
    (take && instr_op == cfc_pkg::CFC_OP_NOP) |=>
      pc_ff == $past(pc_ff) + `CFC_PC_ONE && $stable(sp_ff) && $stable(acc_ff);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state"); // [RL13]
endmodule

// File: cfc_core_tb_top.sv
// Self-checking bench for the flow control instruction unit
`timescale 1ns/1ps
module cfc_core_tb_top;
  // ==========================================
  // Hookup and stack memory
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  cfc_pkg::cfc_op_t instr_op = cfc_pkg::CFC_OP_NOP;
  logic [11:0] instr_target = 12'h000;
  logic [7:0] instr_imm = 8'h00;
  logic wake_req = 1'b0;
  logic instr_ready, stack_wr, global_int_en, flags_we, osc_stop, core_clk_gate;
  logic chip_reset_req, wdt_clear;
  logic [7:0] stack_addr, stack_pointer, working_register, m_sp, m_acc;
  logic [11:0] stack_wdata, stack_rdata, program_counter, m_pc;
  logic [11:0] mem [256];
  logic [11:0] q [$];
  logic m_gie;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  // Combinational read, as the core samples it one cycle after the pop
  assign stack_rdata = mem[stack_addr];
  always @(posedge clk) if (stack_wr === 1'b1) mem[stack_addr] <= stack_wdata;
  cfc_core uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_target(instr_target), .instr_imm(instr_imm), .instr_ready(instr_ready),
    .stack_wr(stack_wr), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
    .stack_rdata(stack_rdata), .wake_req(wake_req), .program_counter(program_counter),
    .stack_pointer(stack_pointer), .working_register(working_register),
    .global_int_en(global_int_en), .flags_we(flags_we), .osc_stop(osc_stop),
    .core_clk_gate(core_clk_gate), .chip_reset_req(chip_reset_req), .wdt_clear(wdt_clear));
  // ==========================================
  // Checking and stimulus tasks
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_st();
    chk("pc", program_counter, m_pc);
    chk("sp", stack_pointer, m_sp);
    chk("acc", working_register, m_acc);
    chk("gie", global_int_en, m_gie);
    chk("flags_we", flags_we, 1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    m_pc = 12'h000;
    m_sp = 8'h00;
    m_acc = 8'h00;
    m_gie = 1'b0;
    q = {};
    @(negedge clk);
    chk_st();
  endtask
  task automatic exec(cfc_pkg::cfc_op_t op, logic [11:0] tgt, logic [7:0] imm);
    logic [11:0] pc1;
    logic two;
    two = op inside {[cfc_pkg::CFC_OP_CALL:cfc_pkg::CFC_OP_PCADD]};
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_target <= tgt;
    instr_imm <= imm;
    @(posedge clk);
    instr_valid <= 1'b0;
    pc1 = m_pc + 12'h001;
    @(negedge clk);
    chk("stack_wr", stack_wr, op == cfc_pkg::CFC_OP_CALL);
    chk("wdt_clear", wdt_clear, op == cfc_pkg::CFC_OP_WDCLR);
    chk("chip_reset_req", chip_reset_req, op == cfc_pkg::CFC_OP_SWRST);
    chk("osc_stop", osc_stop, op == cfc_pkg::CFC_OP_HALT_SYS);
    chk("clk_gate", core_clk_gate, op inside {[cfc_pkg::CFC_OP_HALT_SYS:
      cfc_pkg::CFC_OP_HALT_CPU]});
    chk("ready", instr_ready, !two && op < cfc_pkg::CFC_OP_HALT_SYS
      || op == cfc_pkg::CFC_OP_WDCLR);
    if (op == cfc_pkg::CFC_OP_CALL) begin
      chk("stack_addr", stack_addr, m_sp);
      chk("stack_wdata", stack_wdata, pc1);
      q.push_back(pc1);
    end
    if (op inside {[cfc_pkg::CFC_OP_RETV:cfc_pkg::CFC_OP_RETI]}) begin
      m_sp = m_sp - 8'h02;
      chk("stack_addr", stack_addr, m_sp);
    end
    if (op == cfc_pkg::CFC_OP_RETV) m_acc = imm;
    if (op == cfc_pkg::CFC_OP_GIE_ON) m_gie = 1'b1;
    if (op == cfc_pkg::CFC_OP_GIE_OFF) m_gie = 1'b0;
    m_pc = pc1;
    chk_st();
    if (two) begin
      @(negedge clk);
      case (op)
        cfc_pkg::CFC_OP_CALL: begin
          m_pc = tgt;
          m_sp = m_sp + 8'h02;
        end
        cfc_pkg::CFC_OP_GOTO: m_pc = tgt;
        cfc_pkg::CFC_OP_PCADD: m_pc = pc1 - 12'h001 + {4'h0, m_acc};
        default: m_pc = q.pop_back();
      endcase
      if (op == cfc_pkg::CFC_OP_RETI) m_gie = 1'b1;
      chk_st();
      chk("ready2", instr_ready, 1'b1);
    end
  endtask
  task automatic halt(cfc_pkg::cfc_op_t op);
    int n;
    exec(op, 12'h000, 8'h00);
    repeat (4) @(negedge clk);
    chk("ready_h", instr_ready, 1'b0);
    chk("gate_h", core_clk_gate, 1'b1);
    chk_st();
    @(posedge clk);
    wake_req <= 1'b1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("ready_w", instr_ready, 1'b1);
    chk("gate_w", {core_clk_gate, osc_stop}, 2'b00);
    chk_st();
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Cuts a hang short; the directed and random work needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    cfc_pkg::cfc_op_t op;
    int r;
    r = $urandom(32'hb471);
    for (int i = 0; i < 256; i++) mem[i] = 12'ha5a ^ 12'(i);
    do_reset();
    exec(cfc_pkg::CFC_OP_NOP, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_GIE_ON, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_GIE_OFF, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_WDCLR, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_GOTO, 12'hfff, 8'h00);
    exec(cfc_pkg::CFC_OP_CALL, 12'h123, 8'h00);
    exec(cfc_pkg::CFC_OP_CALL, 12'hffe, 8'h00);
    exec(cfc_pkg::CFC_OP_RETV, 12'h000, 8'hf0);
    exec(cfc_pkg::CFC_OP_PCADD, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_RETI, 12'h000, 8'h00);
    exec(cfc_pkg::CFC_OP_CALL, 12'h0ab, 8'h00);
    exec(cfc_pkg::CFC_OP_RET, 12'h000, 8'h00);
    for (int i = 0; i < 60; i++) begin
      op = cfc_pkg::cfc_op_t'($urandom_range(0, 8));
      if (op inside {[cfc_pkg::CFC_OP_RETV:cfc_pkg::CFC_OP_RETI]} && q.size() == 0) begin
        op = cfc_pkg::CFC_OP_CALL;
      end
      exec(op, 12'($urandom()), 8'($urandom()));
    end
    halt(cfc_pkg::CFC_OP_HALT_SYS);
    halt(cfc_pkg::CFC_OP_HALT_CPU);
    exec(cfc_pkg::CFC_OP_SWRST, 12'h000, 8'h00);
    do_reset();
    exec(cfc_pkg::CFC_OP_NOP, 12'h000, 8'h00);
    summarize();
  end
endmodule
